// ===== lep_regs.vh
// Register map, field positions, reset values and event codes.
`ifndef LEP_REGS_VH
`define LEP_REGS_VH

// Register byte offsets on the APB bus.
`define LEP_CTRL_OFS 12'h000
`define LEP_COUNT_OFS 12'h004
`define LEP_STATUS_OFS 12'h008

// Control register fields.
`define LEP_CTRL_EVENT_LSB 0
`define LEP_CTRL_EVENT_MSB 7
`define LEP_CTRL_UMASK_LSB 8
`define LEP_CTRL_UMASK_MSB 15
`define LEP_CTRL_SIDEBAND_BIT 16
`define LEP_CTRL_ENABLE_BIT 22
`define LEP_CTRL_WMASK 32'h0041ffff
`define LEP_CTRL_RESET 32'h00000000
`define LEP_COUNT_RESET 32'h00000000

// Event codes.
`define LEP_EV_SHARED_MISC 8'h59
`define LEP_EV_AD_ARB_LOSS 8'h30
`define LEP_EV_AD_BYPASS 8'h2c
`define LEP_EV_AD_NOT_EMPTY 8'h27
`define LEP_EV_BLOCK_NOT_EMPTY 8'h28
`define LEP_EV_AD_INSERTS 8'h2d
`define LEP_EV_BLOCK_INSERTS 8'h2e
`define LEP_EV_AD_OCCUPANCY 8'h1c
`define LEP_EV_BLOCK_ARB_LOSS 8'h35
`define LEP_EV_BLOCK_OCCUPANCY 8'h1d
`define LEP_EV_BLOCK_WRITEBACK_OCC 8'h1f
`define LEP_EV_PEER_AD_EMPTY 8'h20
`define LEP_EV_PEER_BLOCK_EMPTY 8'h21

// Unit-mask bits that each event defines; the others are ignored.
`define LEP_UM_ALL 8'hff
`define LEP_UM_BYPASS 8'h0f
`define LEP_UM_SEVEN 8'h7f
`define LEP_UM_WRITEBACK_OCC 8'h77

// Remote shared-pool credit thresholds.
`define LEP_CRED_LT_VN 8'h0a
`define LEP_CRED_LT_RING 8'h05

`endif

// ===== lep_event_counter.v
// Event selection and counting logic for the link egress performance monitor.
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
`include "lep_regs.vh"

// What this block does
// - Event 0x59 bits 0,1: low credit (below 10 or 5) with allocation need.
// - Event 0x59 bits 2,3: shared credits given to one network only.
// - Event 0x59 bits 4-7: credits to one ring only, per network.
// - Event 0x30 counts lost address arbitration, four classes per network.
// - Event 0x2C counts address queue bypass of slots 0-2, early responses.
// - Event 0x27 counts cycles the address queue holds a selected class.
// - Event 0x28 counts cycles the block queue holds a selected class.
// - Events 0x2D and 0x2E count inserts into address and block queues.
// - Insert events watch only their own queue, without direction filtering.
// - Event 0x1C accumulates address queue occupancy over seven classes.
// - Event 0x35 counts lost block arbitration, four classes per network.
// - Event 0x1D sums block queue occupancy, four classes per network.
// - Event 0x1F sums writeback occupancy: local, through, write-pull.
// - Event 0x20 counts cycles without peer address credits, pool or class.
// - Event 0x21 counts missing peer block credits, per sideband mode.
module lep_event_counter
#(
    parameter OCC_W = 4,
    parameter CNT_W = 32
)
(
    // Clock and reset.
    input wire clk_i,
    input wire rst_b_i,
    // APB slave.
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output wire pready_o,
    output wire pslverr_o,
    output wire [31:0] prdata_o,
    // Shared credit pool state.
    input wire [7:0] remote_credit_count_i,
    input wire alloc_vn_needed_i,
    input wire alloc_ring_needed_i,
    input wire [1:0] vn_alloc_i,
    input wire [3:0] ring_alloc_i,
    // Arbitration and bypass conditions.
    input wire [7:0] ad_arb_lost_i,
    input wire [7:0] block_arb_lost_i,
    input wire [3:0] ad_bypass_i,
    // Egress queue inserts and per-class entry counts.
    input wire [7:0] ad_insert_i,
    input wire [7:0] block_insert_i,
    input wire [8*OCC_W-1:0] ad_occ_i,
    input wire [8*OCC_W-1:0] block_occ_i,
    input wire [8*OCC_W-1:0] block_writeback_occ_i,
    // Peer credit exhaustion conditions.
    input wire [6:0] peer_ad_empty_i,
    input wire [6:0] peer_block_empty_i,
    input wire [6:0] peer_block_empty_sideband_i,
    // Counter state.
    output wire [CNT_W-1:0] count_o,
    output wire counting_o
);

    localparam INC_W = OCC_W + 3;

    reg [31:0] ctrl;
    reg [CNT_W-1:0] count;
    reg [INC_W-1:0] last_inc;
    reg [31:0] rd_data;
    reg rd_err;
    reg [INC_W-1:0] next_inc;
    reg [7:0] cond;
    reg [7:0] valid_bits;
    reg occ_event;
    wire [7:0] ev_code;
    wire [7:0] umask;
    wire sideband_mode;
    wire enable;
    wire apb_access;
    wire apb_write;
    wire hit_ctrl;
    wire hit_count;
    wire hit_status;
    wire [7:0] credit_cond;
    wire [7:0] ad_not_empty;
    wire [7:0] block_not_empty;
    wire [INC_W-1:0] ad_occ_sum;
    wire [INC_W-1:0] block_occ_sum;
    wire [INC_W-1:0] writeback_occ_sum;
    wire [7:0] sel_bits;

    // Control register fields.
    assign ev_code = ctrl[`LEP_CTRL_EVENT_MSB:`LEP_CTRL_EVENT_LSB];
    assign umask = ctrl[`LEP_CTRL_UMASK_MSB:`LEP_CTRL_UMASK_LSB];
    assign sideband_mode = ctrl[`LEP_CTRL_SIDEBAND_BIT];
    assign enable = ctrl[`LEP_CTRL_ENABLE_BIT];

    // Adds the per-class entry counts whose mask bit is set.
    function [INC_W-1:0] masked_sum;
        input [8*OCC_W-1:0] occ;
        input [7:0] mask;
        integer k;
        begin
            masked_sum = {INC_W{1'b0}};
            for (k = 0; k < 8; k = k + 1)
            begin
                if (mask[k])
                begin
                    masked_sum = masked_sum +
                        {3'h0, occ[k*OCC_W +: OCC_W]};
                end
            end
        end
    endfunction

    // Shared pool conditions, one per unit-mask bit.
    // low credit levels
    assign credit_cond[0] = (remote_credit_count_i < `LEP_CRED_LT_VN) &&
                            alloc_vn_needed_i;
    assign credit_cond[1] = (remote_credit_count_i < `LEP_CRED_LT_RING) &&
                            alloc_ring_needed_i;
    assign credit_cond[2] = vn_alloc_i[0] && !vn_alloc_i[1];
    assign credit_cond[3] = vn_alloc_i[1] && !vn_alloc_i[0];
    assign credit_cond[4] = ring_alloc_i[0] && !ring_alloc_i[1];
    assign credit_cond[5] = ring_alloc_i[1] && !ring_alloc_i[0];
    assign credit_cond[6] = ring_alloc_i[2] && !ring_alloc_i[3];
    assign credit_cond[7] = ring_alloc_i[3] && !ring_alloc_i[2];

    // Per-class not-empty flags taken from the entry counts.
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : gen_not_empty
            assign ad_not_empty[g] = |ad_occ_i[g*OCC_W +: OCC_W];
            assign block_not_empty[g] = |block_occ_i[g*OCC_W +: OCC_W];
        end
    endgenerate

    // Only the classes that the event defines take part in a sum.
    // undefined bits dropped
    assign sel_bits = umask & valid_bits;

    assign ad_occ_sum = masked_sum(ad_occ_i, sel_bits);
    assign block_occ_sum = masked_sum(block_occ_i, sel_bits);
    assign writeback_occ_sum = masked_sum(block_writeback_occ_i, sel_bits);

    // Event decode: picks the condition vector and its defined mask bits.
    always @*
    begin
        cond = 8'h00;
        valid_bits = 8'h00;
        occ_event = 1'b0;
        case (ev_code)
            `LEP_EV_SHARED_MISC:
            begin
                cond = credit_cond;
                valid_bits = `LEP_UM_ALL;
            end
            `LEP_EV_AD_ARB_LOSS:
            begin
                cond = ad_arb_lost_i;
                valid_bits = `LEP_UM_ALL;
            end
            `LEP_EV_AD_BYPASS:
            begin
                cond = {4'h0, ad_bypass_i};
                valid_bits = `LEP_UM_BYPASS;
            end
            `LEP_EV_AD_NOT_EMPTY:
            begin
                cond = ad_not_empty;
                valid_bits = `LEP_UM_ALL;
            end
            `LEP_EV_BLOCK_NOT_EMPTY:
            begin
                cond = block_not_empty;
                valid_bits = `LEP_UM_ALL;
            end
            `LEP_EV_AD_INSERTS:
            begin
                cond = ad_insert_i;
                valid_bits = `LEP_UM_SEVEN;
            end
            `LEP_EV_BLOCK_INSERTS:
            begin
                cond = block_insert_i;
                valid_bits = `LEP_UM_ALL;
            end
            `LEP_EV_AD_OCCUPANCY:
            begin
                valid_bits = `LEP_UM_SEVEN;
                occ_event = 1'b1;
            end
            `LEP_EV_BLOCK_ARB_LOSS:
            begin
                cond = block_arb_lost_i;
                valid_bits = `LEP_UM_ALL;
            end
            `LEP_EV_BLOCK_OCCUPANCY:
            begin
                valid_bits = `LEP_UM_ALL;
                occ_event = 1'b1;
            end
            `LEP_EV_BLOCK_WRITEBACK_OCC:
            begin
                valid_bits = `LEP_UM_WRITEBACK_OCC;
                occ_event = 1'b1;
            end
            `LEP_EV_PEER_AD_EMPTY:
            begin
                cond = {1'b0, peer_ad_empty_i};
                valid_bits = `LEP_UM_SEVEN;
            end
            `LEP_EV_PEER_BLOCK_EMPTY:
            begin
                if (sideband_mode)
                begin
                    cond = {1'b0, peer_block_empty_sideband_i};
                end
                else
                begin
                    cond = {1'b0, peer_block_empty_i};
                end
                valid_bits = `LEP_UM_SEVEN;
            end
            default:
            begin
                cond = 8'h00;
                valid_bits = 8'h00;
            end
        endcase
    end

    // Per-cycle increment: OR of selected conditions, or an entry sum.
    always @*
    begin
        next_inc = {INC_W{1'b0}};
        if (enable)
        begin
            if (occ_event)
            begin
                if (ev_code == `LEP_EV_AD_OCCUPANCY)
                begin
                    next_inc = ad_occ_sum;
                end
                else if (ev_code == `LEP_EV_BLOCK_OCCUPANCY)
                begin
                    next_inc = block_occ_sum;
                end
                else
                begin
                    next_inc = writeback_occ_sum;
                end
            end
            else if (|(cond & sel_bits))
            begin
                next_inc = {{(INC_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // APB decode; the slave answers every access without wait states.
    assign apb_access = psel_i && penable_i;
    assign apb_write = apb_access && pwrite_i;
    assign hit_ctrl = (paddr_i == `LEP_CTRL_OFS);
    assign hit_count = (paddr_i == `LEP_COUNT_OFS);
    assign hit_status = (paddr_i == `LEP_STATUS_OFS);

    // Read multiplexer; an unmapped address reads zero with an error.
    always @*
    begin
        rd_data = 32'h00000000;
        rd_err = 1'b0;
        if (hit_ctrl)
        begin
            rd_data = ctrl;
        end
        else if (hit_count)
        begin
            rd_data = count;
        end
        else if (hit_status)
        begin
            rd_data = {{(32-INC_W){1'b0}}, last_inc};
        end
        else
        begin
            rd_err = 1'b1;
        end
    end

    assign pready_o = 1'b1;
    assign pslverr_o = apb_access && rd_err;
    assign prdata_o = (apb_access && !pwrite_i) ? rd_data : 32'h00000000;

    // Control register; only defined bits are writable.
    always @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            ctrl <= `LEP_CTRL_RESET;
        end
        else if (apb_write && hit_ctrl)
        begin
            ctrl <= pwdata_i & `LEP_CTRL_WMASK;
        end
    end

    // Counter: a software write loads it, otherwise it adds the increment.
    always @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            count <= `LEP_COUNT_RESET;
        end
        else if (apb_write && hit_count)
        begin
            count <= pwdata_i;
        end
        else
        begin
            count <= count + {{(CNT_W-INC_W){1'b0}}, next_inc};
        end
    end

    // Last increment, visible to software as a live status value.
    always @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            last_inc <= {INC_W{1'b0}};
        end
        else
        begin
            last_inc <= next_inc;
        end
    end

    assign count_o = count;
    assign counting_o = enable;

endmodule

// ===== lep_event_counter_monitor.sv
// Checker for the bus answers and counting of the event counter.
`timescale 1ns/1ps
`include "lep_regs.vh"
module lep_monitor
#(
    parameter OCC_W = 4,
    parameter CNT_W = 32
)
(
    // Clock and reset.
    input wire clk_i,
    input wire rst_b_i,
    // Register bus.
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire pready_o,
    input wire pslverr_o,
    input wire [31:0] prdata_o,
    // Counting.
    input wire [7:0] ad_arb_lost_i,
    input wire [CNT_W-1:0] count_o,
    input wire counting_o
);
    // Access phase and address decode, as seen on the pins.
    wire acc = psel_i && penable_i;
    wire bad = paddr_i != 12'h000 && paddr_i != 12'h004 && paddr_i != 12'h008;
    reg [31:0] ctl;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    // Shadow of the control register, so counting can be tied to it.
    always @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            ctl <= `LEP_CTRL_RESET;
        end
        else if (acc && pwrite_i && paddr_i == 12'h000)
        begin
            ctl <= pwdata_i & `LEP_CTRL_WMASK;
        end
    end
    ready_const_a: assert property (pready_o)
        else $error("pready low");
    unmapped_err_a: assert property (acc && bad |-> pslverr_o)
        else $error("no error on unmapped access");
    mapped_ok_a: assert property (acc && !bad |-> !pslverr_o)
        else $error("error on mapped access");
    idle_rdata_a: assert property (!(acc && !pwrite_i)
        |-> prdata_o == 0) else $error("read data outside read access");
    count_read_a: assert property (acc && !pwrite_i
        && paddr_i == 12'h004 |-> prdata_o == count_o)
        else $error("count read mismatch");
    count_load_a: assert property (acc && pwrite_i
        && paddr_i == 12'h004 |=> count_o == $past(pwdata_i))
        else $error("count not loaded");
    counting_bit_a: assert property (counting_o == ctl[22])
        else $error("counting flag wrong");
    count_hold_a: assert property (!ctl[22] && !(acc && pwrite_i)
        |=> $stable(count_o)) else $error("count moved while off");
    arb_loss_a: assert property (ctl[22] && ctl[7:0] == 8'h30 && !acc
        && |(ctl[15:8] & ad_arb_lost_i) |=> count_o == $past(count_o) + 1)
        else $error("arbitration loss not counted");
endmodule
bind lep_event_counter lep_monitor #(.OCC_W(OCC_W), .CNT_W(CNT_W)) mon (
    .clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pready_o, .pslverr_o, .prdata_o, .ad_arb_lost_i, .count_o, .counting_o);

// ===== tb.sv
// Self-checking bench for the event counter.
`timescale 1ns/1ps
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x); end end
module tb;
    logic clk_i = 1'b0, rst_b_i = 1'b0, psel = 0, penable = 0, pwrite = 0;
    logic vneed = 0, rneed = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, ado = '0, blo = '0, wbo = '0;
    logic [7:0] cred = '0, ada = '0, bla = '0, adi = '0, bli = '0;
    logic [6:0] pad = '0, pbl = '0, pbs = '0;
    logic [3:0] byp = '0, rna = '0;
    logic [1:0] shared_credit_pool = '0;
    wire pready, pslverr, counting;
    wire [31:0] prdata, count;
    int fail_count = 0, cmp_count = 0, cyc = 0;
    logic [7:0] evs [13] = '{8'h30, 8'h35, 8'h2d, 8'h2e, 8'h2c, 8'h20, 8'h21,
        8'h27, 8'h28, 8'h1c, 8'h1d, 8'h1f, 8'h00};
    logic [7:0] def [13] = '{8'hff, 8'hff, 8'h7f, 8'hff, 8'h0f, 8'h7f, 8'h7f,
        8'hff, 8'hff, 8'h7f, 8'hff, 8'h77, 8'h00};
    lep_event_counter DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pready_o(pready), .pslverr_o(pslverr),
        .prdata_o(prdata), .remote_credit_count_i(cred),
        .alloc_vn_needed_i(vneed), .alloc_ring_needed_i(rneed),
        .vn_alloc_i(shared_credit_pool), .ring_alloc_i(rna), .ad_arb_lost_i(ada),
        .block_arb_lost_i(bla), .ad_bypass_i(byp), .ad_insert_i(adi),
        .block_insert_i(bli), .ad_occ_i(ado), .block_occ_i(blo),
        .block_writeback_occ_i(wbo), .peer_ad_empty_i(pad),
        .peer_block_empty_i(pbl), .peer_block_empty_sideband_i(pbs),
        .count_o(count),
        .counting_o(counting));
    // Free-running clock at 200 MHz.
    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end
    // Cuts a hang short.
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fail_count++;
            stop_test;
        end
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // One bus transfer; the request holds until pready is seen high.
    task automatic apb(input w, input [11:0] a, input [31:0] d,
        output [31:0] r, output e);
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do @(posedge clk_i); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Counts one event over eight enabled cycles and checks the total.
    task automatic run(input [7:0] ev, input [7:0] um, input sb,
        input [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1, 12'h004, 0, r, e);
        apb(1, 12'h000, {9'h0, 1'b1, 5'h0, sb, um, ev}, r, e);
        repeat (5) @(posedge clk_i);
        `CHK(counting, 1'b1)
        apb(1, 12'h000, 0, r, e);
        apb(0, 12'h004, 0, r, e);
        `CHK(r, x)
        `CHK(count, x)
    endtask
    task automatic t_regs;
        logic [31:0] r;
        logic e;
        apb(0, 12'h000, 0, r, e);
        `CHK(r, 32'h0)
        apb(0, 12'h008, 0, r, e);
        `CHK(r, 32'h0)
        apb(1, 12'h000, 32'hffffffff, r, e);
        apb(0, 12'h000, 0, r, e);
        `CHK(r, 32'h0041ffff)
        apb(1, 12'h000, 0, r, e);
        apb(1, 12'h004, 32'h12345678, r, e);
        apb(0, 12'h004, 0, r, e);
        `CHK(r, 32'h12345678)
        apb(0, 12'h00c, 0, r, e);
        `CHK({e, r}, 33'h100000000)
        $display("test regs done");
    endtask
    task automatic t_credit;
        cred <= 8'h09;
        vneed <= 1'b1;
        run(8'h59, 8'h01, 0, 8);
        cred <= 8'h0a;
        run(8'h59, 8'h01, 0, 0);
        {vneed, rneed, cred} <= {2'b01, 8'h04};
        run(8'h59, 8'h02, 0, 8);
        cred <= 8'h05;
        run(8'h59, 8'h02, 0, 0);
        {rneed, shared_credit_pool} <= 3'b001;
        run(8'h59, 8'h04, 0, 8);
        run(8'h59, 8'h08, 0, 0);
        {shared_credit_pool, rna} <= 6'b110001;
        run(8'h59, 8'h04, 0, 0);
        run(8'h59, 8'h10, 0, 8);
        {shared_credit_pool, rna} <= 6'b001000;
        run(8'h59, 8'h80, 0, 8);
        run(8'h59, 8'h40, 0, 0);
        rna <= 4'h2;
        run(8'h59, 8'h20, 0, 8);
        rna <= 4'h4;
        run(8'h59, 8'h40, 0, 8);
        rna <= 4'h0;
        $display("test credit done");
    endtask
    task automatic t_table;
        logic [7:0] s;
        logic [31:0] o;
        for (int k = 0; k < 13; k++)
            for (int i = 0; i < 8; i++)
            begin
                s = 8'h01 << i;
                o = 32'h3 << (4 * i);
                {ada, bla, adi, bli, byp} <= {s, s, s, s, s[3:0]};
                {pad, pbl, ado, blo, wbo} <= {s[6:0], s[6:0], o, o, o};
                // each event but 0x59 against each mask bit.
                run(evs[k], s, 0, def[k][i] ? ((k > 8) ? 24 : 8) : 0);
                run(evs[k], ~s, 0, 0);
            end
        $display("test table done");
    endtask
    task automatic t_side;
        logic [31:0] r;
        logic e;
        {pbl, pbs, ado} <= {7'h00, 7'h01, 32'h52};
        run(8'h21, 8'h01, 1, 8);
        run(8'h21, 8'h01, 0, 0);
        run(8'h1c, 8'h03, 0, 56);
        // Status shows the live per-cycle increment while counting.
        apb(1, 12'h000, 32'h0040031c, r, e);
        apb(0, 12'h008, 0, r, e);
        `CHK(r, 32'h7)
        apb(1, 12'h000, 0, r, e);
        // Each insert event follows its own queue only.
        {adi, bli} <= {8'h01, 8'h00};
        run(8'h2e, 8'h01, 0, 0);
        run(8'h2d, 8'h01, 0, 8);
        $display("test side done");
    endtask
    // Reset, then the scenarios in turn.
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_regs;
        t_credit;
        t_table;
        t_side;
        stop_test;
    end
endmodule
